/* File: src/ibcs_sequencer.sv */
// Operation
// - Divide: internal, read low word, internal, high word
// - Zero then magnitude checks branch to overflow exit
// - Twenty cycles, quotient overflow sets flag, exits
// - Success: write quotient, prefetch, write remainder
// - Unary group: fetch, prefetch, store back source
// - Workspace operand uses workspace code instead
// - Address-only fetch drops read on last cycle
// - External: four internal, I/O, flag word, prefetch
// - I/O write cycle lasts at least two states
// - Idle: three internal, I/O, fetch, one internal
// - Parallel load: fetch, base read, two internal, I/O
// - Post-incremented base register access becomes write
module ibcs_sequencer #(
    parameter int IO_STATES = ibcs_pkg::IO_MIN_STATES
) (
    input  wire logic             clock_i,        // 20 MHz clock
    input  wire logic             nrst_i,         // Async reset, low
    input  wire logic             start_i,        // Begin sequence
    input  wire ibcs_pkg::ibcs_op_e op_i,         // Instruction class
    input  wire logic [3:0]       src_cycles_i,   // Source fetch cycles
    input  wire logic             src_in_ws_i,    // Operand in workspace
    input  wire logic             addr_only_i,    // Address, no operand
    input  wire logic             base_register_twelve_postinc_i, // Base reg post-inc
    input  wire logic             zero_div_i,     // Divisor is zero
    input  wire logic             mag_ovf_i,      // Divisor too small
    input  wire logic             quot_ovf_i,     // Quotient too wide
    output logic [3:0]            status_o,       // Bus status code
    output logic                  rd_o,           // Read cycle
    output logic                  wr_o,           // Write cycle
    output logic                  busy_o,         // Sequence running
    output logic                  done_o,         // Sequence finished
    output logic                  overflow_flag_bit_o // Set status bit 4
);
    import ibcs_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE,
        S_SRC,
        S_STEP
    } ibcs_state_e;

    // ------------------------------------------------------------------
    // Step table
    // ------------------------------------------------------------------
    function automatic ibcs_step_s mk(input logic [3:0] code,
        input logic rd, input logic wr, input logic [4:0] cnt,
        input logic last, input ibcs_chk_e chk, input logic ws_sub,
        input logic inc_wr);
        mk = '{code, rd, wr, cnt, last, chk, ws_sub, inc_wr};
    endfunction
    function automatic ibcs_step_s step_f(input ibcs_op_e op,
                                          input logic [3:0] idx);
        logic [4:0] io_n;
        io_n = 5'(IO_STATES);
        step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, ONE_CYCLE, 1'b1,
                    CHK_NONE, 1'b0, 1'b0);
        case (op)
            OP_SIGNED_DIVIDE: begin
                case (idx)
                    4'h0: step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h1: step_f = mk(WORKSPACE_ACCESS_CODE, 1'b1, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h2: step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h3: step_f = mk(WORKSPACE_ACCESS_CODE, 1'b1, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h4: step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0,
                        DIV_ZERO_WAIT, 1'b0, CHK_ZERO, 1'b0, 1'b0);
                    4'h5: step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0,
                        DIV_MAG_WAIT, 1'b0, CHK_MAG, 1'b0, 1'b0);
                    4'h6: step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0,
                        DIV_QUOT_WAIT, 1'b0, CHK_QUOT, 1'b0, 1'b0);
                    4'h7: step_f = mk(WORKSPACE_ACCESS_CODE, 1'b0, 1'b1,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h8: step_f = mk(INSTRUCTION_FETCH_CODE, 1'b1, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h9: step_f = mk(WORKSPACE_ACCESS_CODE, 1'b0, 1'b1,
                        ONE_CYCLE, 1'b1, CHK_NONE, 1'b0, 1'b0);
                    4'ha: step_f = mk(INSTRUCTION_FETCH_CODE, 1'b1, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    default: step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0,
                        ONE_CYCLE, 1'b1, CHK_NONE, 1'b0, 1'b0);
                endcase
            end
            OP_UNARY: begin
                if (idx == 4'h0) begin
                    step_f = mk(INSTRUCTION_FETCH_ALIAS, 1'b1, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                end else begin
                    step_f = mk(SOURCE_OPERAND_CODE, 1'b0, 1'b1,
                        ONE_CYCLE, 1'b1, CHK_NONE, 1'b1, 1'b0);
                end
            end
            OP_EXTERNAL: begin
                case (idx)
                    4'h0: step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0,
                        EXT_INTERNAL, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h1: step_f = mk(IO_CYCLE_CODE, 1'b0, 1'b1,
                        io_n, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h2: step_f = mk(FLAG_WORD_OUTPUT_CODE, 1'b0, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h3: step_f = mk(INSTRUCTION_FETCH_CODE, 1'b1, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    default: ;
                endcase
            end
            OP_IDLE: begin
                case (idx)
                    4'h0: step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0,
                        IDLE_INTERNAL, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h1: step_f = mk(IO_CYCLE_CODE, 1'b0, 1'b1,
                        io_n, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h2: step_f = mk(INSTRUCTION_FETCH_CODE, 1'b1, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    default: ;
                endcase
            end
            OP_PARALLEL_LOAD: begin
                case (idx)
                    4'h0: step_f = mk(WORKSPACE_ACCESS_CODE, 1'b1, 1'b0,
                        ONE_CYCLE, 1'b0, CHK_NONE, 1'b0, 1'b1);
                    4'h1: step_f = mk(INTERNAL_CYCLE_CODE, 1'b0, 1'b0,
                        LOAD_INTERNAL, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    4'h2: step_f = mk(IO_CYCLE_CODE, 1'b0, 1'b1,
                        io_n, 1'b0, CHK_NONE, 1'b0, 1'b0);
                    default: step_f = mk(INSTRUCTION_FETCH_ALIAS, 1'b1,
                        1'b0, ONE_CYCLE, 1'b1, CHK_NONE, 1'b0, 1'b0);
                endcase
            end
            default: ;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    ibcs_state_e state_r, state_nxt;
    ibcs_op_e    op_r, op_sel;
    logic [3:0]  idx_r, idx_nxt, left_r, left_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic        ws_r, addr_only_r, pinc_r, ws_sel, pinc_sel;
    logic [5:0]  out_nxt;
    logic        done_nxt, ovf_nxt, emit, hit;
    ibcs_step_s  cur_s, nxt_s;
    assign op_sel   = (state_r == S_IDLE) ? op_i : op_r;
    assign ws_sel   = (state_r == S_IDLE) ? src_in_ws_i : ws_r;
    assign pinc_sel = (state_r == S_IDLE) ? base_register_twelve_postinc_i : pinc_r;
    assign cur_s    = step_f(op_r, idx_r);
    assign hit = (cur_s.chk == CHK_ZERO && zero_div_i) ||
                 (cur_s.chk == CHK_MAG && mag_ovf_i) ||
                 (cur_s.chk == CHK_QUOT && quot_ovf_i);
    always_comb begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        cnt_nxt   = cnt_r;
        left_nxt  = left_r;
        out_nxt   = {status_o, rd_o, wr_o};
        done_nxt  = 1'b0;
        ovf_nxt   = 1'b0;
        emit      = 1'b0;
        nxt_s     = cur_s;
        case (state_r)
            S_IDLE: begin
                out_nxt = {INTERNAL_CYCLE_CODE, 2'b00};
                if (start_i && src_cycles_i != 4'h0) begin
                    state_nxt = S_SRC;
                    left_nxt  = src_cycles_i - 4'h1;
                    out_nxt = {src_in_ws_i ? WORKSPACE_ACCESS_CODE
                                           : SOURCE_OPERAND_CODE,
                               !(addr_only_i && src_cycles_i == 4'h1),
                               1'b0};
                end else if (start_i) begin
                    state_nxt = S_STEP;
                    idx_nxt   = 4'h0;
                    emit      = 1'b1;
                end
            end
            S_SRC: begin
                if (left_r != 4'h0) begin
                    left_nxt = left_r - 4'h1;
                    out_nxt = {ws_r ? WORKSPACE_ACCESS_CODE
                                    : SOURCE_OPERAND_CODE,
                               !(addr_only_r && left_r == 4'h1),
                               1'b0};
                end else begin
                    state_nxt = S_STEP;
                    idx_nxt   = 4'h0;
                    emit      = 1'b1;
                end
            end
            S_STEP: begin
                if (cnt_r != 5'h00) begin
                    cnt_nxt = cnt_r - 5'h01;
                end else if (hit) begin
                    idx_nxt = DIV_IDX_EXIT;
                    ovf_nxt = (cur_s.chk == CHK_QUOT);
                    emit    = 1'b1;
                end else if (cur_s.last) begin
                    state_nxt = S_IDLE;
                    done_nxt  = 1'b1;
                    out_nxt   = {INTERNAL_CYCLE_CODE, 2'b00};
                end else begin
                    idx_nxt = idx_r + 4'h1;
                    emit    = 1'b1;
                end
            end
            default: state_nxt = S_IDLE;
        endcase
        if (emit) begin
            nxt_s   = step_f(op_sel, idx_nxt);
            cnt_nxt = nxt_s.cnt - 5'h01;
            out_nxt = {(nxt_s.ws_sub && ws_sel) ? WORKSPACE_ACCESS_CODE
                                                : nxt_s.code,
                       nxt_s.rd && !(nxt_s.inc_wr && pinc_sel),
                       nxt_s.wr || (nxt_s.inc_wr && pinc_sel)};
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= S_IDLE;
            idx_r   <= 4'h0;
            cnt_r   <= 5'h00;
            left_r  <= 4'h0;
        end else begin
            state_r <= state_nxt;
            idx_r   <= idx_nxt;
            cnt_r   <= cnt_nxt;
            left_r  <= left_nxt;
        end
    end

    // Instruction attributes are held so that inputs may change mid-run.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            op_r        <= OP_SIGNED_DIVIDE;
            ws_r        <= 1'b0;
            addr_only_r <= 1'b0;
            pinc_r      <= 1'b0;
        end else if (state_r == S_IDLE && start_i) begin
            op_r        <= op_i;
            ws_r        <= src_in_ws_i;
            addr_only_r <= addr_only_i;
            pinc_r      <= base_register_twelve_postinc_i;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_o            <= INTERNAL_CYCLE_CODE;
            rd_o                <= 1'b0;
            wr_o                <= 1'b0;
            busy_o              <= 1'b0;
            done_o              <= 1'b0;
            overflow_flag_bit_o <= 1'b0;
        end else begin
            {status_o, rd_o, wr_o} <= out_nxt;
            busy_o              <= (state_nxt != S_IDLE);
            done_o              <= done_nxt;
            overflow_flag_bit_o <= ovf_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic div_on, first_step;
    assign div_on     = (state_r == S_STEP) && (op_r == OP_SIGNED_DIVIDE);
    assign first_step = (state_r == S_STEP) && (idx_r == 4'h0);
    a_idle_quiet: assert property (!busy_o |->
        status_o == INTERNAL_CYCLE_CODE && !rd_o && !wr_o)
        else $error("idle bus not internal");
    a_div_lead: assert property (div_on && idx_r == 4'h0 |->
        status_o == INTERNAL_CYCLE_CODE ##1
        status_o == WORKSPACE_ACCESS_CODE && rd_o ##1
        status_o == INTERNAL_CYCLE_CODE ##1
        status_o == WORKSPACE_ACCESS_CODE && rd_o)
        else $error("divide lead-in wrong");
    a_div_zero_exit: assert property (div_on && idx_r == DIV_IDX_ZERO &&
        cnt_r == 5'h00 && zero_div_i |=>
        idx_r == DIV_IDX_EXIT && !overflow_flag_bit_o)
        else $error("zero divisor not exited");
    a_div_quot_flag: assert property (div_on && idx_r == DIV_IDX_QUOT &&
        cnt_r == 5'h00 && quot_ovf_i |=> overflow_flag_bit_o)
        else $error("quotient overflow flag missing");
    a_div_result: assert property (div_on && idx_r == DIV_IDX_RESULT &&
        cnt_r == 5'h00 |->
        status_o == WORKSPACE_ACCESS_CODE && wr_o ##1
        status_o == INSTRUCTION_FETCH_CODE && rd_o ##1
        status_o == WORKSPACE_ACCESS_CODE && wr_o ##1 done_o)
        else $error("divide result order wrong");
    a_div_ovf_exit: assert property (overflow_flag_bit_o |->
        status_o == INSTRUCTION_FETCH_CODE && rd_o ##1
        status_o == INTERNAL_CYCLE_CODE && !wr_o ##1 done_o)
        else $error("overflow exit wrong");
    a_unary_store: assert property (first_step && op_r == OP_UNARY |->
        status_o == INSTRUCTION_FETCH_ALIAS && rd_o ##1 wr_o &&
        status_o == (ws_r ? WORKSPACE_ACCESS_CODE
                          : SOURCE_OPERAND_CODE))
        else $error("unary store wrong");
    a_src_block: assert property (state_r == S_SRC && left_r == 4'h0 |->
        rd_o == !addr_only_r)
        else $error("source read not blocked");
    a_ext_seq: assert property (first_step && op_r == OP_EXTERNAL &&
        cnt_r == 5'h03 |->
        (status_o == INTERNAL_CYCLE_CODE)[*4] ##1
        status_o == IO_CYCLE_CODE && wr_o)
        else $error("external sequence wrong");
    a_io_len: assert property (status_o == IO_CYCLE_CODE &&
        $changed(status_o) |=> status_o == IO_CYCLE_CODE)
        else $error("I/O cycle too short");
    a_idle_seq: assert property (first_step && op_r == OP_IDLE &&
        cnt_r == 5'h02 |->
        (status_o == INTERNAL_CYCLE_CODE)[*3] ##1
        status_o == IO_CYCLE_CODE && wr_o)
        else $error("idle sequence wrong");
    a_load_base: assert property (first_step &&
        op_r == OP_PARALLEL_LOAD |->
        status_o == WORKSPACE_ACCESS_CODE && wr_o == pinc_r &&
        rd_o == !pinc_r ##1
        (status_o == INTERNAL_CYCLE_CODE)[*2] ##1
        status_o == IO_CYCLE_CODE && wr_o)
        else $error("parallel load sequence wrong");
    c_div_ok: cover property (div_on && idx_r == DIV_IDX_RESULT ##3 done_o);
    c_div_ovf: cover property (overflow_flag_bit_o ##2 done_o);
    c_ext_done: cover property (busy_o && op_r == OP_EXTERNAL ##1 done_o);
    c_load_inc: cover property (first_step && op_r == OP_PARALLEL_LOAD &&
        pinc_r);
endmodule

/* File: src/ibcs_pkg.sv */
package ibcs_pkg;

    // ------------------------------------------------------------------
    // Bus status codes
    // ------------------------------------------------------------------
    localparam logic [3:0] INTERNAL_CYCLE_CODE     = 4'h9;
    localparam logic [3:0] WORKSPACE_ACCESS_CODE   = 4'h6;
    localparam logic [3:0] INSTRUCTION_FETCH_CODE  = 4'h3;
    localparam logic [3:0] INSTRUCTION_FETCH_ALIAS = 4'h3;
    localparam logic [3:0] SOURCE_OPERAND_CODE     = 4'h1;
    localparam logic [3:0] IO_CYCLE_CODE           = 4'hb;
    localparam logic [3:0] FLAG_WORD_OUTPUT_CODE   = 4'hd;

    // ------------------------------------------------------------------
    // Cycle counts and step indices
    // ------------------------------------------------------------------
    localparam logic [4:0] ONE_CYCLE        = 5'h01;
    localparam logic [4:0] DIV_ZERO_WAIT    = 5'h03;
    localparam logic [4:0] DIV_MAG_WAIT     = 5'h03;
    localparam logic [4:0] DIV_QUOT_WAIT    = 5'h14;
    localparam logic [4:0] EXT_INTERNAL     = 5'h04;
    localparam logic [4:0] IDLE_INTERNAL    = 5'h03;
    localparam logic [4:0] LOAD_INTERNAL    = 5'h02;
    localparam int         IO_MIN_STATES    = 2;
    localparam logic [3:0] DIV_IDX_ZERO     = 4'h4;
    localparam logic [3:0] DIV_IDX_QUOT     = 4'h6;
    localparam logic [3:0] DIV_IDX_RESULT   = 4'h7;
    localparam logic [3:0] DIV_IDX_EXIT     = 4'ha;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_SIGNED_DIVIDE,
        OP_UNARY,
        OP_EXTERNAL,
        OP_IDLE,
        OP_PARALLEL_LOAD
    } ibcs_op_e;

    typedef enum logic [1:0] {
        CHK_NONE,
        CHK_ZERO,
        CHK_MAG,
        CHK_QUOT
    } ibcs_chk_e;

    typedef struct packed {
        logic [3:0] code;
        logic       rd;
        logic       wr;
        logic [4:0] cnt;
        logic       last;
        ibcs_chk_e  chk;
        logic       ws_sub;
        logic       inc_wr;
    } ibcs_step_s;

endpackage

/* File: verification/ibcs_bus_monitor.sv */
// ----------------------------------------------------------------------
// Bus-side decoder: logs one entry per machine cycle while busy.
// ----------------------------------------------------------------------
module ibcs_bus_monitor (
    input  wire logic       clock_i,  // Processor clock
    input  wire logic       nrst_i,   // Async reset, low
    input  wire logic [3:0] status_i, // Bus status code
    input  wire logic       rd_i,     // Read cycle
    input  wire logic       wr_i,     // Write cycle
    input  wire logic       busy_i,   // Sequence running
    input  wire logic       flag_i    // Overflow flag pulse
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [6:0] log_q[$];

    // Devices decode the code on every clock, so each cycle is one entry.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            log_q.delete();
        end else if (busy_i === 1'b1) begin
            log_q.push_back({flag_i, status_i, rd_i, wr_i});
        end
    end
endmodule

/* File: verification/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ibcs_pkg::*;

    localparam int IO_N = 2;
    logic       clock_i = 1'b0;
    logic       nrst_i  = 1'b0;
    logic       start_i = 1'b0;
    ibcs_op_e   op_i    = OP_UNARY;
    logic [3:0] src_cycles_i = 4'h0;
    logic       src_in_ws_i, addr_only_i, base_register_twelve_postinc_i;
    logic       zero_div_i, mag_ovf_i, quot_ovf_i;
    logic [3:0] status_o;
    logic       rd_o, wr_o, busy_o, done_o, overflow_flag_bit_o;
    int         n_errors  = 0;
    int         tests_run = 0;
    logic [6:0] exp_q[$];

    initial {src_in_ws_i, addr_only_i, base_register_twelve_postinc_i} = 3'h0;
    initial {zero_div_i, mag_ovf_i, quot_ovf_i} = 3'h0;
    always #25 clock_i = ~clock_i;

    ibcs_sequencer #(.IO_STATES(IO_N)) u_ibcs_sequencer (
        .clock_i(clock_i), .nrst_i(nrst_i), .start_i(start_i), .op_i(op_i),
        .src_cycles_i(src_cycles_i), .src_in_ws_i(src_in_ws_i),
        .addr_only_i(addr_only_i), .base_register_twelve_postinc_i(base_register_twelve_postinc_i),
        .zero_div_i(zero_div_i), .mag_ovf_i(mag_ovf_i),
        .quot_ovf_i(quot_ovf_i), .status_o(status_o), .rd_o(rd_o),
        .wr_o(wr_o), .busy_o(busy_o), .done_o(done_o),
        .overflow_flag_bit_o(overflow_flag_bit_o));

    ibcs_bus_monitor u_ibcs_bus_monitor (
        .clock_i(clock_i), .nrst_i(nrst_i), .status_i(status_o),
        .rd_i(rd_o), .wr_i(wr_o), .busy_i(busy_o),
        .flag_i(overflow_flag_bit_o));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic close_out;
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [6:0] got, input logic [6:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t cycle got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic push(input logic [3:0] c, input logic r, input logic w,
                        input int n, input logic f = 1'b0);
        repeat (n) exp_q.push_back({f, c, r, w});
    endtask

    task automatic src(input int n, input logic ws, input logic ao);
        for (int i = 0; i < n; i++)
            push(ws ? WORKSPACE_ACCESS_CODE : SOURCE_OPERAND_CODE,
                 !(ao && i == n - 1), 1'b0, 1);
    endtask

    // Called at a falling edge; returns at the falling clock edge while done_o is high,
    // so the next call starts back to back in the done cycle.
    task automatic run(input ibcs_op_e op, input logic [3:0] n,
                       input logic [5:0] flags);
        int k;
        k = 0;
        u_ibcs_bus_monitor.log_q.delete();
        op_i = op;
        src_cycles_i = n;
        {src_in_ws_i, addr_only_i, base_register_twelve_postinc_i} = flags[5:3];
        {zero_div_i, mag_ovf_i, quot_ovf_i} = flags[2:0];
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        while (done_o !== 1'b1 && k < 200) begin
            @(negedge clock_i);
            k++;
        end
        if (k >= 200) begin
            n_errors++;
            $display("ERROR %0t sequence never finished", $time);
        end
        check({status_o, rd_o, wr_o, busy_o},
              {INTERNAL_CYCLE_CODE, 3'h0});
        tests_run++;
        if (u_ibcs_bus_monitor.log_q.size() != exp_q.size()) begin
            n_errors++;
            $display("ERROR %0t cycle count %0d exp %0d", $time,
                     u_ibcs_bus_monitor.log_q.size(), exp_q.size());
        end else begin
            foreach (exp_q[i])
                check(u_ibcs_bus_monitor.log_q[i], exp_q[i]);
        end
        exp_q.delete();
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic div_head;
        src(1, 1'b0, 1'b0);
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 1);
        push(WORKSPACE_ACCESS_CODE, 1'b1, 1'b0, 1);
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 1);
        push(WORKSPACE_ACCESS_CODE, 1'b1, 1'b0, 1);
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 3);
    endtask

    task automatic div_exit(input logic f);
        push(INSTRUCTION_FETCH_CODE, 1'b1, 1'b0, 1, f);
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 1);
    endtask

    task automatic t_div_ok;
        div_head();
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 23);
        push(WORKSPACE_ACCESS_CODE, 1'b0, 1'b1, 1);
        push(INSTRUCTION_FETCH_CODE, 1'b1, 1'b0, 1);
        push(WORKSPACE_ACCESS_CODE, 1'b0, 1'b1, 1);
        run(OP_SIGNED_DIVIDE, 4'h1, 6'h00);
    endtask

    task automatic t_div_fail;
        div_head();
        div_exit(1'b0);
        run(OP_SIGNED_DIVIDE, 4'h1, 6'h07);
        div_head();
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 3);
        div_exit(1'b0);
        run(OP_SIGNED_DIVIDE, 4'h1, 6'h03);
        div_head();
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 23);
        div_exit(1'b1);
        run(OP_SIGNED_DIVIDE, 4'h1, 6'h01);
    endtask

    task automatic t_unary;
        src(2, 1'b1, 1'b0);
        push(INSTRUCTION_FETCH_CODE, 1'b1, 1'b0, 1);
        push(WORKSPACE_ACCESS_CODE, 1'b0, 1'b1, 1);
        run(OP_UNARY, 4'h2, 6'h20);
        src(2, 1'b0, 1'b1);
        push(INSTRUCTION_FETCH_CODE, 1'b1, 1'b0, 1);
        push(SOURCE_OPERAND_CODE, 1'b0, 1'b1, 1);
        run(OP_UNARY, 4'h2, 6'h10);
    endtask

    task automatic t_ext_idle;
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 4);
        push(IO_CYCLE_CODE, 1'b0, 1'b1, IO_N);
        push(FLAG_WORD_OUTPUT_CODE, 1'b0, 1'b0, 1);
        div_exit(1'b0);
        run(OP_EXTERNAL, 4'h0, 6'h00);
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 3);
        push(IO_CYCLE_CODE, 1'b0, 1'b1, IO_N);
        div_exit(1'b0);
        run(OP_IDLE, 4'h0, 6'h00);
    endtask

    task automatic t_load(input logic pi, input logic [3:0] n);
        src(n, 1'b0, 1'b0);
        push(WORKSPACE_ACCESS_CODE, !pi, pi, 1);
        push(INTERNAL_CYCLE_CODE, 1'b0, 1'b0, 2);
        push(IO_CYCLE_CODE, 1'b0, 1'b1, IO_N);
        push(INSTRUCTION_FETCH_CODE, 1'b1, 1'b0, 1);
        run(OP_PARALLEL_LOAD, n, {2'h0, pi, 3'h0});
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        @(negedge clock_i);
        check({status_o, rd_o, wr_o, busy_o},
              {INTERNAL_CYCLE_CODE, 3'h0});
        @(negedge clock_i);
        nrst_i = 1'b1;
        t_div_ok();
        t_div_fail();
        t_unary();
        t_ext_idle();
        t_load(1'b0, 4'h1);
        t_load(1'b1, 4'h0);
        close_out();
    end

    // Every sequence is well under 50 cycles; this leaves wide margin.
    initial begin
        #(50 * 3000);
        n_errors++;
        close_out();
    end
endmodule
